// File: verilog/wshd_map.svh
`ifndef WSHD_MAP_SVH
`define WSHD_MAP_SVH

// host address layout, register offsets are word spaced
`define WSHD_ADDR_W 12
`define WSHD_FIFO_SEL_BIT 11
`define WSHD_UNUSED_HI 10
`define WSHD_UNUSED_LO 6
`define WSHD_OFF_HI 5
`define WSHD_OFF_LO 1

// register offsets with special handling
`define WSHD_OFF_DP 5'h10
`define WSHD_OFF_GAP 5'h11
`define WSHD_OFF_LOW_ONLY 5'h1e
`define WSHD_OFF_RESET 5'h1f

// reset values
`define WSHD_CSR_RESET 8'h00
`define WSHD_DATA_RESET 16'h0000

`endif

// File: verilog/wshd_pkg.sv
package wshd_pkg;

    // what one host access decodes to
    typedef enum logic [2:0] {
        WSHD_ACC_NONE,
        WSHD_ACC_CSR,
        WSHD_ACC_DP,
        WSHD_ACC_RESET
    } wshd_acc_e;

    typedef logic [7:0] wshd_byte_t;

endpackage

// File: verilog/wshd_stream_if.sv
`timescale 1ns/1ps
`default_nettype none

interface wshd_stream_if #(
    parameter int W = 16
);
    logic valid;
    logic ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// File: verilog/wshd_buf.sv
`timescale 1ns/1ps
`default_nettype none

// small fifo; depth must be a power of two so pointers wrap naturally
module wshd_buf
    import wshd_pkg::*;
#(
    parameter int W = 16,
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // fill and drain sides
    wshd_stream_if.snk in_s,
    wshd_stream_if.src out_s
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic [AW:0] next_cnt;
    logic push;
    logic pop;

    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;
    assign out_s.data = mem[rp];

    always_comb begin
        next_cnt = cnt;
        if (push && !pop) begin
            next_cnt = cnt + 1'b1;
        end else if (pop && !push) begin
            next_cnt = cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt <= '0;
            out_s.valid <= 1'b0;
            in_s.ready <= 1'b0;
        end else begin
            cnt <= next_cnt;
            out_s.valid <= (next_cnt != '0);
            in_s.ready <= (next_cnt != (AW+1)'(DEPTH));
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wp <= '0;
            rp <= '0;
        end else begin
            if (push) begin
                wp <= wp + 1'b1;
            end
            if (pop) begin
                rp <= rp + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wp] <= in_s.data;
        end
    end

    // a full buffer never takes a word, so nothing is overwritten
    property p_buf_no_overrun;
        @(posedge clk_i) disable iff (!rst_n_i)
        (cnt == (AW+1)'(DEPTH)) |-> !in_s.ready;
    endproperty
    a_buf_no_overrun: assert property (p_buf_no_overrun)
        else $error("buffer accepts while full");

endmodule

`default_nettype wire

// File: verilog/wshd_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "wshd_map.svh"

module wshd_top
    import wshd_pkg::*;
#(
    parameter int AW = `WSHD_ADDR_W,
    parameter int DW = 16,
    parameter int BUF_DEPTH = 2
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // host bus pins
    input wire logic host_cs_n_i,
    input wire logic host_rd_n_i,
    input wire logic host_wr_n_i,
    input wire logic [AW-1:0] host_addr_i,
    input wire logic [DW-1:0] host_data_bus_i,
    output logic [DW-1:0] host_data_bus_o,
    output logic host_data_bus_oe_o,
    // power-up straps
    input wire logic eeprom_chip_select_strap_i,
    input wire logic eeprom_clock_strap_i,
    output logic bus_mode_isa_o,
    // register write strobe and read-triggered reset pulse to the device core
    output logic csr_wr_o,
    output logic [4:0] csr_wr_off_o,
    output logic [7:0] csr_wr_data_o,
    output logic dev_reset_o,
    // received packet words from the buffer memory
    input wire logic [DW-1:0] rx_data_i,
    input wire logic rx_valid_i,
    output logic rx_ready_o,
    // transmit packet words to the buffer memory
    output logic [DW-1:0] tx_data_o,
    output logic tx_valid_o,
    input wire logic tx_ready_i
);
    // pin synchronisers, first stage read only by the second
    logic cs_s1, cs_s2, rd_s1, rd_s2, rd_s3, wr_s1, wr_s2, wr_s3;
    logic [AW-1:0] addr_s1, addr_s2;
    logic [DW-1:0] din_s1, din_s2;
    logic eeprom_chip_select_strap_s1, eeprom_chip_select_strap_s2, eeprom_clock_strap_s1, eeprom_clock_strap_s2;
    logic strap_done;
    logic rd_evt, wr_evt;
    wshd_acc_e acc;
    logic [4:0] off;
    wshd_byte_t csr_byte [32];
    logic [DW-1:0] rd_word;
    logic rx_pop, tx_push;
    logic [DW-1:0] tx_word;

    wshd_stream_if #(.W(DW)) rx_in ();
    wshd_stream_if #(.W(DW)) rx_out ();
    wshd_stream_if #(.W(DW)) tx_in ();
    wshd_stream_if #(.W(DW)) tx_out ();

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            {cs_s1, cs_s2} <= 2'h3;
            {rd_s1, rd_s2, rd_s3} <= 3'h7;
            {wr_s1, wr_s2, wr_s3} <= 3'h7;
            addr_s1 <= '0;
            addr_s2 <= '0;
            din_s1 <= '0;
            din_s2 <= '0;
        end else begin
            cs_s1 <= host_cs_n_i;
            cs_s2 <= cs_s1;
            rd_s1 <= host_rd_n_i;
            rd_s2 <= rd_s1;
            rd_s3 <= rd_s2;
            wr_s1 <= host_wr_n_i;
            wr_s2 <= wr_s1;
            wr_s3 <= wr_s2;
            addr_s1 <= host_addr_i;
            addr_s2 <= addr_s1;
            din_s1 <= host_data_bus_i;
            din_s2 <= din_s1;
        end
    end

    // strap chain stays out of reset so it holds the real levels when reset lifts
    always_ff @(posedge clk_i) begin
        eeprom_chip_select_strap_s1 <= eeprom_chip_select_strap_i;
        eeprom_chip_select_strap_s2 <= eeprom_chip_select_strap_s1;
        eeprom_clock_strap_s1 <= eeprom_clock_strap_i;
        eeprom_clock_strap_s2 <= eeprom_clock_strap_s1;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            strap_done <= 1'b0;
            bus_mode_isa_o <= 1'b0;
        end else if (!strap_done) begin
            strap_done <= 1'b1;
            bus_mode_isa_o <= !eeprom_chip_select_strap_s2 && !eeprom_clock_strap_s2;
        end
    end

    // read acts at strobe start, write at strobe end when data is settled
    assign rd_evt = bus_mode_isa_o && !cs_s2 && !rd_s2 && rd_s3;
    assign wr_evt = bus_mode_isa_o && !cs_s2 && wr_s2 && !wr_s3;
    assign off = addr_s2[`WSHD_OFF_HI:`WSHD_OFF_LO];

    always_comb begin
        acc = WSHD_ACC_NONE;
        if (addr_s2[`WSHD_FIFO_SEL_BIT]) begin
            acc = WSHD_ACC_DP;
        end else if (addr_s2[`WSHD_UNUSED_HI:`WSHD_UNUSED_LO] != '0) begin
            acc = WSHD_ACC_NONE;
        end else if (off == `WSHD_OFF_DP) begin
            acc = WSHD_ACC_DP;
        end else if (off == `WSHD_OFF_GAP) begin
            acc = WSHD_ACC_NONE;
        end else if (off == `WSHD_OFF_RESET && rd_evt) begin
            acc = WSHD_ACC_RESET;
        end else begin
            acc = WSHD_ACC_CSR;
        end
    end

    always_comb begin
        rd_word = `WSHD_DATA_RESET;
        case (acc)
            WSHD_ACC_CSR: begin
                if (off == `WSHD_OFF_LOW_ONLY) begin
                    rd_word = {8'h00, csr_byte[off]};
                end else if (off[0]) begin
                    rd_word = {csr_byte[off], csr_byte[off]};
                end else begin
                    rd_word = {csr_byte[off | 5'h01], csr_byte[off]};
                end
            end
            WSHD_ACC_DP: begin
                rd_word = rx_out.valid ? rx_out.data : `WSHD_DATA_RESET;
            end
            default: begin
                rd_word = `WSHD_DATA_RESET;
            end
        endcase
    end

    // host data drive, held for the whole read strobe
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            host_data_bus_o <= `WSHD_DATA_RESET;
            host_data_bus_oe_o <= 1'b0;
        end else if (rd_evt) begin
            host_data_bus_o <= rd_word;
            host_data_bus_oe_o <= 1'b1;
        end else if (rd_s2 || cs_s2) begin
            host_data_bus_oe_o <= 1'b0;
        end
    end

    // low lane only into register storage
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 32; i++) begin
                csr_byte[i] <= `WSHD_CSR_RESET;
            end
        end else if (wr_evt && acc == WSHD_ACC_CSR) begin
            csr_byte[off] <= din_s2[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            csr_wr_o <= 1'b0;
            csr_wr_off_o <= '0;
            csr_wr_data_o <= '0;
            dev_reset_o <= 1'b0;
        end else begin
            csr_wr_o <= wr_evt && acc == WSHD_ACC_CSR;
            if (wr_evt && acc == WSHD_ACC_CSR) begin
                csr_wr_off_o <= off;
                csr_wr_data_o <= din_s2[7:0];
            end
            dev_reset_o <= rd_evt && acc == WSHD_ACC_RESET;
        end
    end

    // one word per access, any address in the window
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rx_pop <= 1'b0;
            tx_push <= 1'b0;
            tx_word <= `WSHD_DATA_RESET;
        end else begin
            rx_pop <= rd_evt && acc == WSHD_ACC_DP && rx_out.valid;
            // a write while the buffer is full is dropped; host must pace
            tx_push <= wr_evt && acc == WSHD_ACC_DP && tx_in.ready;
            if (wr_evt && acc == WSHD_ACC_DP) begin
                tx_word <= din_s2;
            end
        end
    end

    assign rx_in.valid = rx_valid_i;
    assign rx_in.data = rx_data_i;
    assign rx_ready_o = rx_in.ready;
    assign rx_out.ready = rx_pop;
    assign tx_in.valid = tx_push;
    assign tx_in.data = tx_word;
    assign tx_valid_o = tx_out.valid;
    assign tx_data_o = tx_out.data;
    assign tx_out.ready = tx_ready_i;

    wshd_buf #(.W(DW), .DEPTH(BUF_DEPTH)) u_rx_buf (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .in_s(rx_in),
        .out_s(rx_out)
    );

    wshd_buf #(.W(DW), .DEPTH(BUF_DEPTH)) u_tx_buf (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .in_s(tx_in),
        .out_s(tx_out)
    );

    property p_dp_low_read;
        @(posedge clk_i) disable iff (!rst_n_i)
        (rd_evt && rx_out.valid && addr_s2 == 12'h020) |=> rx_pop ##1 !rx_pop;
    endproperty
    a_dp_low_read: assert property (p_dp_low_read)
        else $error("read at 20h did not pop one word");

    property p_even_read;
        @(posedge clk_i) disable iff (!rst_n_i)
        (rd_evt && acc == WSHD_ACC_CSR && !off[0] && off != `WSHD_OFF_LOW_ONLY)
            |=> host_data_bus_oe_o && host_data_bus_o[7:0] == csr_byte[$past(off)];
    endproperty
    a_even_read: assert property (p_even_read)
        else $error("even register read wrong low lane");

    property p_odd_read;
        @(posedge clk_i) disable iff (!rst_n_i)
        (rd_evt && acc == WSHD_ACC_CSR && off[0])
            |=> host_data_bus_o[15:8] == host_data_bus_o[7:0];
    endproperty
    a_odd_read: assert property (p_odd_read)
        else $error("odd register read lanes differ");

    property p_low_only;
        @(posedge clk_i) disable iff (!rst_n_i)
        (rd_evt && acc == WSHD_ACC_CSR && off == `WSHD_OFF_LOW_ONLY)
            |=> host_data_bus_o[15:8] == 8'h00;
    endproperty
    a_low_only: assert property (p_low_only)
        else $error("offset 1e read drove high lane");

    property p_low_lane_write;
        @(posedge clk_i) disable iff (!rst_n_i)
        (wr_evt && acc == WSHD_ACC_CSR)
            |=> csr_byte[$past(off)] == $past(din_s2[7:0]) && csr_wr_o;
    endproperty
    a_low_lane_write: assert property (p_low_lane_write)
        else $error("register write did not store low lane");

    property p_reset_read;
        @(posedge clk_i) disable iff (!rst_n_i)
        (rd_evt && !addr_s2[11] && addr_s2[10:0] == 11'h03e) |=> dev_reset_o ##1 !dev_reset_o;
    endproperty
    a_reset_read: assert property (p_reset_read)
        else $error("read of 1f gave no single reset pulse");

    property p_unused;
        @(posedge clk_i) disable iff (!rst_n_i)
        ((rd_evt || wr_evt) && !addr_s2[11] && addr_s2[10:6] != 5'h00)
            |=> !csr_wr_o && !tx_push && !rx_pop && !dev_reset_o;
    endproperty
    a_unused: assert property (p_unused)
        else $error("unused address range had an effect");

    property p_window_write;
        @(posedge clk_i) disable iff (!rst_n_i)
        (wr_evt && addr_s2[11] && tx_in.ready) |=> tx_push && tx_word == $past(din_s2);
    endproperty
    a_window_write: assert property (p_window_write)
        else $error("window write did not push its word");

    property p_strap;
        @(posedge clk_i) disable iff (!rst_n_i)
        (!strap_done && (eeprom_chip_select_strap_s2 || eeprom_clock_strap_s2)) |=> !bus_mode_isa_o;
    endproperty
    a_strap: assert property (p_strap)
        else $error("pull-up strap still selected this bus setting");

endmodule

`default_nettype wire

// File: test/wshd_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

// buffer memory stand-in: finite rx word source, stallable tx sink
module wshd_mem_model #(
    parameter int N = 6
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // rx source
    input wire logic rx_en_i,
    input wire logic rx_ready_i,
    output logic rx_valid_o,
    output logic [15:0] rx_data_o,
    // tx sink
    input wire logic tx_en_i,
    input wire logic tx_valid_i,
    input wire logic [15:0] tx_data_i,
    output logic tx_ready_o
);
    int idx;
    int tx_n;
    logic [15:0] tx_got [0:7];
    logic [15:0] word;

    assign word = 16'h1000 + 16'(idx);
    assign rx_valid_o = rx_en_i && (idx < N);
    // idle data inverted so a stale word never passes for a fresh one
    assign rx_data_o = rx_valid_o ? word : ~word;
    assign tx_ready_o = tx_en_i;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            idx <= 0;
            tx_n <= 0;
        end else begin
            if (rx_valid_o && rx_ready_i) begin
                idx <= idx + 1;
            end
            if (tx_valid_i && tx_ready_o) begin
                tx_got[tx_n[2:0]] <= tx_data_i;
                tx_n <= tx_n + 1;
            end
        end
    end
endmodule

`default_nettype wire

// File: test/wshd_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module wshd_top_tb_top;
    import wshd_pkg::*;
    logic clk_i;
    logic rst_n_i;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [11:0] addr;
    logic [15:0] din;
    logic [15:0] dout;
    logic oe;
    logic s_cs;
    logic s_ck;
    logic mode;
    logic csr_wr;
    logic [4:0] wr_off_o;
    logic [7:0] wr_dat_o;
    logic dev_rst;
    logic [15:0] rx_data;
    logic rx_valid;
    logic rx_ready;
    logic [15:0] tx_data;
    logic tx_valid;
    logic tx_ready;
    logic rx_en;
    logic tx_en;
    int fail_count = 0;
    int checks = 0;
    int rst_pulses = 0;
    logic wr_seen;
    logic [4:0] wr_off;
    logic [7:0] wr_dat;
    logic [15:0] rd;
    logic [15:0] exp_q [$];
    logic [11:0] adr_q [$];
    logic [11:0] dp_a [7] = '{12'h020, 12'h800, 12'h802, 12'hffe, 12'h020, 12'hc00, 12'h800};

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    wshd_top DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .host_cs_n_i(cs_n), .host_rd_n_i(rd_n),
        .host_wr_n_i(wr_n), .host_addr_i(addr), .host_data_bus_i(din), .host_data_bus_o(dout),
        .host_data_bus_oe_o(oe), .eeprom_chip_select_strap_i(s_cs),
        .eeprom_clock_strap_i(s_ck), .bus_mode_isa_o(mode), .csr_wr_o(csr_wr),
        .csr_wr_off_o(wr_off_o), .csr_wr_data_o(wr_dat_o), .dev_reset_o(dev_rst),
        .rx_data_i(rx_data), .rx_valid_i(rx_valid), .rx_ready_o(rx_ready),
        .tx_data_o(tx_data), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready));

    wshd_mem_model #(.N(6)) mem (.clk_i(clk_i), .rst_n_i(rst_n_i), .rx_en_i(rx_en),
        .rx_ready_i(rx_ready), .rx_valid_o(rx_valid), .rx_data_o(rx_data), .tx_en_i(tx_en),
        .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready));

    always @(posedge clk_i) begin
        if (dev_rst === 1'b1) begin
            rst_pulses++;
        end
    end

    function automatic logic [7:0] bval(input int off);
        return {3'h5, 5'(off)};
    endfunction

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic hreset(input logic cs_strap, input logic ck_strap);
        @(posedge clk_i);
        s_cs <= cs_strap;
        s_ck <= ck_strap;
        rst_n_i <= 0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1;
        repeat (6) @(posedge clk_i);
    endtask

    task automatic hread(input logic [11:0] a, output logic [15:0] d);
        int n;
        @(posedge clk_i);
        addr <= a;
        cs_n <= 0;
        rd_n <= 0;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (oe !== 1'b1 && n < 12);
        d = dout;
        chk("read_oe", {15'h0, oe}, 16'h0001);
        rd_n <= 1;
        cs_n <= 1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (oe !== 1'b0 && n < 12);
        repeat (3) @(posedge clk_i);
    endtask

    task automatic hwrite(input logic [11:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr <= a;
        din <= d;
        cs_n <= 0;
        wr_n <= 0;
        wr_seen = 0;
        repeat (4) @(posedge clk_i);
        wr_n <= 1;
        repeat (8) begin
            @(posedge clk_i);
            if (csr_wr === 1'b1) begin
                wr_seen = 1;
                wr_off = wr_off_o;
                wr_dat = wr_dat_o;
            end
        end
        cs_n <= 1;
        repeat (3) @(posedge clk_i);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #(40 * 20000);
        fail_count++;
        final_report();
    end

    initial begin
        rst_n_i <= 1'b0;
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        addr <= 12'h000;
        din <= 16'h0000;
        s_cs <= 1'b0;
        s_ck <= 1'b0;
        rx_en <= 1'b0;
        tx_en <= 1'b0;
        hreset(0, 0);
        chk("mode", {15'h0, mode}, 16'h0001); // straps low
        hread(12'h000, rd);
        chk("reset_regs", rd, 16'h0000);
        // word spaced writes, high lane junk
        for (int off = 0; off < 32; off++) begin
            if (off == 16 || off == 17) continue;
            hwrite(12'(off * 2), {8'hff, bval(off)});
            chk("wr_seen", {15'h0, wr_seen}, 16'h0001);
            chk("wr_off", {11'h0, wr_off}, 16'(off));
            chk("wr_dat", {8'h0, wr_dat}, {8'h0, bval(off)});
            if (off < 30) begin
                adr_q.push_back(12'(off * 2));
                exp_q.push_back(off % 2 ? {bval(off), bval(off)} : {bval(off + 1), bval(off)});
            end
        end
        adr_q.push_back(12'h03c);
        exp_q.push_back({8'h00, bval(30)});
        adr_q.push_back(12'h022);
        exp_q.push_back(16'h0000);
        adr_q.push_back(12'h040);
        exp_q.push_back(16'h0000);
        adr_q.push_back(12'h7fe);
        exp_q.push_back(16'h0000);
        for (int k = 0; k < adr_q.size(); k++) begin
            hread(adr_q[k], rd);
            chk("csr_read", rd, exp_q[k]);
        end
        $display("test register map done");
        // alias of offset 0 with unused address bits set
        hwrite(12'h100, 16'h0077);
        chk("unused_wr", {15'h0, wr_seen}, 16'h0000);
        hread(12'h000, rd);
        chk("unused_alias", rd, {bval(1), bval(0)});
        $display("test unused range done");
        // far side fills the two-entry buffer while host is idle
        rx_en <= 1;
        repeat (8) @(posedge clk_i);
        chk("rx_full", {15'h0, rx_ready}, 16'h0000);
        // mixed window addresses, in no order, stream consecutive words
        for (int k = 0; k < 7; k++) begin
            hread(dp_a[k], rd);
            chk("dp_read", rd, k < 6 ? 16'h1000 + 16'(k) : 16'h0000);
        end
        $display("test rx data port done");
        // tx sink stalled: third word must be dropped
        hwrite(12'h020, 16'hbeef);
        hwrite(12'h800, 16'h1234);
        chk("dp_no_csr", {15'h0, wr_seen}, 16'h0000);
        hwrite(12'ha00, 16'h5555); // third window write, dropped while buffer full
        chk("tx_valid", {15'h0, tx_valid}, 16'h0001);
        chk("tx_held", 16'(mem.tx_n), 16'h0000);
        tx_en <= 1;
        repeat (6) @(posedge clk_i);
        chk("tx_count", 16'(mem.tx_n), 16'h0002);
        chk("tx_w0", mem.tx_got[0], 16'hbeef);
        chk("tx_w1", mem.tx_got[1], 16'h1234);
        chk("tx_idle", {15'h0, tx_valid}, 16'h0000);
        $display("test tx data port done");
        hwrite(12'h03e, 16'hffaa);
        chk("top_wr_off", {11'h0, wr_off}, 16'h001f);
        chk("top_wr_dat", {8'h0, wr_dat}, 16'h00aa);
        chk("top_wr_norst", 16'(rst_pulses), 16'h0000);
        hread(12'h03e, rd);
        chk("top_rd", rd, 16'h0000);
        chk("top_rd_rst", 16'(rst_pulses), 16'h0001);
        $display("test device reset done");
        // any pull-up disables this bus setting
        for (int s = 1; s < 4; s++) begin
            hreset(s[1], s[0]);
            chk("mode_off", {15'h0, mode}, 16'h0000);
            hwrite(12'h000, 16'h0011);
            chk("mode_off_wr", {15'h0, wr_seen}, 16'h0000);
        end
        hreset(0, 0);
        chk("mode_on", {15'h0, mode}, 16'h0001);
        $display("test strap modes done");
        final_report();
    end
endmodule

`default_nettype wire
